/* verilog/adc_cycle_ctrl.v */
`timescale 1ns/10ps
`default_nettype none
`include "adc_cycle_defines.vh"

module adc_cycle_ctrl #(
  parameter POR_CYCLES  = `POR_CYCLES,   // power-on pulse length in clk cycles
  parameter CONV_CYCLES = `CONV_CYCLES,  // conversion length in clk cycles
  parameter ISCK_HALF   = 4              // internal serial clock half period
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // supply monitor, high while supply is below threshold
  input  wire        supply_low,
  // modulator result feed, one pulse per finished conversion
  input  wire        sample_valid,
  output wire        sample_ready,
  input  wire [20:0] sample_data,
  input  wire        sample_over,
  input  wire        sample_under,
  input  wire        sample_polarity,
  // serial port pins
  input  wire        cs_n,
  input  wire        sck_in,
  output reg         sck_out_ff,
  output reg         sck_oe_n_ff,
  output reg         sdo_ff,
  output reg         sdo_oe_n_ff,
  // status
  output reg         converting_ff,
  output reg         sleeping_ff,
  output reg         calibrating_ff,
  output reg         int_sck_mode_ff
);

  // ****************************************
  // states
  // ****************************************
  localparam ST_POR   = 2'b00;
  localparam ST_CONV  = 2'b01;
  localparam ST_SLEEP = 2'b10;
  localparam ST_OUT   = 2'b11;

  // counts the power-on pulse and conversion timer
  localparam CW = 24;

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg  cs_meta_ff;      // first stage, read only by second
  reg  cs_sync_ff;      // synchronised chip select
  reg  cs_prev_ff;      // for edge detection
  reg  sck_meta_ff;
  reg  sck_sync_ff;
  reg  sck_prev_ff;
  reg  sup_meta_ff;
  reg  sup_sync_ff;

  // two flops on every outside level
  always @(posedge clk) begin
    if (rst) begin
      cs_meta_ff  <= 1'b1;
      cs_sync_ff  <= 1'b1;
      cs_prev_ff  <= 1'b1;
      sck_meta_ff <= 1'b0;
      sck_sync_ff <= 1'b0;
      sck_prev_ff <= 1'b0;
      sup_meta_ff <= 1'b1;
      sup_sync_ff <= 1'b1;
    end else begin
      cs_meta_ff  <= cs_n;
      cs_sync_ff  <= cs_meta_ff;
      cs_prev_ff  <= cs_sync_ff;
      sck_meta_ff <= sck_in;
      sck_sync_ff <= sck_meta_ff;
      sck_prev_ff <= sck_sync_ff;
      sup_meta_ff <= supply_low;
      sup_sync_ff <= sup_meta_ff;
    end
  end

  wire cs_fall = cs_prev_ff && !cs_sync_ff;
  // rise/fall of whichever clock drives the shifter
  reg  isck_rise;
  reg  isck_fall;
  wire ext_rise = !sck_prev_ff && sck_sync_ff;
  wire ext_fall = sck_prev_ff && !sck_sync_ff;
  wire clk_rise = int_sck_mode_ff ? isck_rise : ext_rise;
  wire clk_fall = int_sck_mode_ff ? isck_fall : ext_fall;

  // ****************************************
  // internal reset from supply monitor
  // ****************************************
  reg [CW-1:0] por_cnt_ff;   // counts the clearing pulse
  reg          por_ff;       // internal reset active
  wire         ireset = rst || sup_sync_ff || por_ff;

  // held while supply low, then a fixed pulse
  always @(posedge clk) begin
    if (rst || sup_sync_ff) begin
      por_ff     <= 1'b1;
      por_cnt_ff <= {CW{1'b0}};
    end else if (por_ff) begin
      if (por_cnt_ff == POR_CYCLES[CW-1:0] - 1'b1) begin
        por_ff <= 1'b0;
      end else begin
        por_cnt_ff <= por_cnt_ff + 1'b1;
      end
    end
  end

  // ****************************************
  // result fifo between modulator and shifter
  // ****************************************
  wire [23:0] fifo_out;
  wire        fifo_valid;
  reg         fifo_take;
  wire [23:0] fifo_in = {sample_polarity, sample_over, sample_under, sample_data};

  result_fifo #(
    .WIDTH (24),
    .DEPTH (`FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk         (clk),
    .rst         (ireset),
    .in_valid    (sample_valid),
    .in_ready    (sample_ready),
    .in_data     (fifo_in),
    .out_valid   (fifo_valid),
    .out_ready   (fifo_take),
    .out_data_ff (fifo_out)
  );

  // clamp code selection for out-of-range input
  function [20:0] clamp;
    input [22:0] w;
    begin
      if (w[22]) begin
        clamp = `RES_OVER;
      end else if (w[21]) begin
        clamp = `RES_UNDER;
      end else begin
        clamp = w[20:0];
      end
    end
  endfunction

  // ****************************************
  // main cycle
  // ****************************************
  reg [1:0]               state_ff;
  reg [CW-1:0]            conv_cnt_ff;     // conversion timer
  reg [`WORD_BITS-1:0]    shift_ff;        // output shift register
  reg [4:0]               bits_ff;         // bits shifted so far
  reg                     started_ff;      // first rising edge seen
  reg [3:0]               isck_cnt_ff;     // internal clock divider
  reg                     isck_lvl_ff;

  // polarity travels through the fifo beside its own sample, so a
  // stalled host never sees the sign of a later sample paired with
  // an earlier result

  // the conversion ends when its time is up and a sample exists;
  // calibration runs within that same time so no extra state
  wire conv_done = (conv_cnt_ff >= CONV_CYCLES[CW-1:0] - 1'b1) && fifo_valid;

  always @(posedge clk) begin
    if (ireset) begin
      state_ff        <= ST_POR;
      conv_cnt_ff     <= {CW{1'b0}};
      shift_ff        <= {`WORD_BITS{1'b0}};
      bits_ff         <= 5'h00;
      started_ff      <= 1'b0;
      fifo_take       <= 1'b0;
      int_sck_mode_ff <= 1'b0;
      calibrating_ff  <= 1'b0;
    end else begin
      fifo_take <= 1'b0;
      case (state_ff)
        ST_POR: begin
          // mode sampled from the pin once after power-up
          int_sck_mode_ff <= sck_sync_ff;
          state_ff        <= ST_CONV;
          conv_cnt_ff     <= {CW{1'b0}};
        end
        ST_CONV: begin
          // last eighth of the conversion time is calibration
          calibrating_ff <= (conv_cnt_ff >= (CONV_CYCLES[CW-1:0] >> 3) * 3'h7);
          // a select during conversion still picks the clock mode
          if (cs_fall) begin
            int_sck_mode_ff <= sck_sync_ff;
          end
          if (!conv_done) begin
            if (conv_cnt_ff < CONV_CYCLES[CW-1:0] - 1'b1) begin
              conv_cnt_ff <= conv_cnt_ff + 1'b1;
            end
          end else begin
            // whole word in one step: pending low, filler low
            shift_ff <= {1'b0, 1'b0,
                         fifo_out[22] ? 1'b1 : (fifo_out[21] ? 1'b0 : fifo_out[23]),
                         clamp(fifo_out[22:0])};
            fifo_take      <= 1'b1;
            calibrating_ff <= 1'b0;
            state_ff       <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          // shift register untouched while asleep
          if (cs_fall) begin
            int_sck_mode_ff <= sck_sync_ff;
            bits_ff         <= 5'h00;
            started_ff      <= 1'b0;
            state_ff        <= ST_OUT;
          end
        end
        ST_OUT: begin
          if (cs_sync_ff) begin
            if (started_ff) begin
              state_ff    <= ST_CONV;
              conv_cnt_ff <= {CW{1'b0}};
            end else begin
              state_ff <= ST_SLEEP;
            end
          end else begin
            if (clk_rise) begin
              started_ff <= 1'b1;
            end
            if (clk_fall && started_ff) begin
              shift_ff <= {shift_ff[`WORD_BITS-2:0], 1'b1};
              if (bits_ff == `WORD_BITS - 1) begin
                state_ff    <= ST_CONV;
                conv_cnt_ff <= {CW{1'b0}};
              end else begin
                bits_ff <= bits_ff + 1'b1;
              end
            end
          end
        end
        default: begin
          state_ff <= ST_POR;
        end
      endcase
    end
  end

  // ****************************************
  // internal serial clock generator
  // ****************************************
  // runs only while shifting in internal mode; half period fixed by ISCK_HALF
  always @(posedge clk) begin
    if (ireset || state_ff != ST_OUT || cs_sync_ff || !int_sck_mode_ff) begin
      isck_cnt_ff <= 4'h0;
      isck_lvl_ff <= 1'b0;
      isck_rise   <= 1'b0;
      isck_fall   <= 1'b0;
    end else begin
      isck_rise <= 1'b0;
      isck_fall <= 1'b0;
      if (isck_cnt_ff == ISCK_HALF[3:0] - 1'b1) begin
        isck_cnt_ff <= 4'h0;
        isck_lvl_ff <= !isck_lvl_ff;
        isck_rise   <= !isck_lvl_ff;
        isck_fall   <= isck_lvl_ff;
      end else begin
        isck_cnt_ff <= isck_cnt_ff + 1'b1;
      end
    end
  end

  // ****************************************
  // pin drivers and status
  // ****************************************
  // mode choice comes from pin timing only, never a register
  always @(posedge clk) begin
    if (ireset) begin
      sdo_ff        <= 1'b1;
      sdo_oe_n_ff   <= 1'b1;
      sck_out_ff    <= 1'b0;
      sck_oe_n_ff   <= 1'b1;
      converting_ff <= 1'b1;
      sleeping_ff   <= 1'b0;
    end else begin
      sdo_oe_n_ff   <= cs_sync_ff;
      sck_oe_n_ff   <= !(int_sck_mode_ff && !cs_sync_ff);
      sck_out_ff    <= isck_lvl_ff;
      converting_ff <= (state_ff == ST_CONV) || (state_ff == ST_POR);
      sleeping_ff   <= (state_ff == ST_SLEEP);
      if (state_ff == ST_OUT) begin
        sdo_ff <= shift_ff[`POS_PENDING];
      end else begin
        sdo_ff <= (state_ff != ST_SLEEP);
      end
    end
  end

endmodule

`default_nettype wire

/* verilog/adc_cycle_defines.vh */
`ifndef ADC_CYCLE_DEFINES_VH
`define ADC_CYCLE_DEFINES_VH

// output word layout
`define WORD_BITS          24
`define RESULT_BITS        21
`define POS_PENDING        23
`define POS_FILLER         22
`define POS_POLARITY       21

// power-on reset pulse length
`define POR_TIME_US        1000
`define CLK_MHZ            10
`define POR_CYCLES         (`POR_TIME_US * `CLK_MHZ)

// default length of one conversion in clk cycles
`define CONV_CYCLES        2000

// result clamp codes for out-of-range input
`define RES_OVER           21'h100000
`define RES_UNDER          21'h0FFFFF

// fifo of finished results
`define FIFO_DEPTH         8

`endif

/* verilog/result_fifo.v */
`timescale 1ns/10ps
`default_nettype none
`include "adc_cycle_defines.vh"

// small fifo; read data comes out of a register
module result_fifo #(
  parameter WIDTH = 23,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data_ff
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];  // storage
  reg [AW:0]      wr_ff;            // write pointer with wrap bit
  reg [AW:0]      rd_ff;            // read pointer with wrap bit
  reg             have_ff;          // output register holds a word
  wire            mem_empty;
  wire            full;
  wire            load;

  assign mem_empty = (wr_ff == rd_ff);
  assign full      = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
  // nothing is taken while held in reset, so no offered word is lost
  assign in_ready  = !full && !rst;
  assign out_valid = have_ff;
  // refill the output register when empty or being taken
  assign load      = !mem_empty && (!have_ff || out_ready);

  // write side
  always @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ff[AW-1:0]] <= in_data;
    end
  end

  // pointers and output register
  always @(posedge clk) begin
    if (rst) begin
      wr_ff       <= {(AW+1){1'b0}};
      rd_ff       <= {(AW+1){1'b0}};
      have_ff     <= 1'b0;
      out_data_ff <= {WIDTH{1'b0}};
    end else begin
      if (in_valid && in_ready) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (load) begin
        out_data_ff <= mem[rd_ff[AW-1:0]];
        rd_ff       <= rd_ff + 1'b1;
        have_ff     <= 1'b1;
      end else if (out_ready) begin
        have_ff <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* sim/adc_cycle_ctrl_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************
// port checker
// ****************
module adc_cycle_ctrl_sva #(
  parameter int POR_CYCLES  = 20,
  parameter int CONV_CYCLES = 50
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // supply and feed
  input wire logic        supply_low,
  input wire logic        sample_valid,
  input wire logic        sample_ready,
  input wire logic [20:0] sample_data,
  input wire logic        sample_over,
  input wire logic        sample_under,
  input wire logic        sample_polarity,
  // serial pins
  input wire logic        cs_n,
  input wire logic        sck_in,
  input wire logic        sck_out_ff,
  input wire logic        sck_oe_n_ff,
  input wire logic        sdo_ff,
  input wire logic        sdo_oe_n_ff,
  // status
  input wire logic        converting_ff,
  input wire logic        sleeping_ff,
  input wire logic        calibrating_ff,
  input wire logic        int_sck_mode_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // cycles since the last reset of any kind, saturating
  logic [15:0] up_cnt_ff;
  always_ff @(posedge clk) begin
    if (rst || supply_low) begin
      up_cnt_ff <= 16'h0000;
    end else if (up_cnt_ff != 16'hFFFF) begin
      up_cnt_ff <= up_cnt_ff + 16'h0001;
    end
  end
  // ****************
  // assertions
  // ****************
  sleep_after_conv_a: assert property ($fell(converting_ff) |-> ##[0:1] sleeping_ff)
    else $error("no sleep after conversion");
  sleep_holds_a: assert property (disable iff (rst || supply_low)
    sleeping_ff && cs_n ##1 cs_n [*4] |-> sleeping_ff) else $error("sleep left with cs high");
  wake_on_select_a: assert property (sleeping_ff && !cs_n ##1 !cs_n [*4] |-> !sleeping_ff)
    else $error("select did not wake");
  hiz_cs_high_a: assert property (cs_n [*5] |-> sdo_oe_n_ff)
    else $error("data pin driven while deselected");
  status_busy_a: assert property (!sdo_oe_n_ff && $past(!sdo_oe_n_ff) && converting_ff
    && $past(converting_ff) |-> sdo_ff) else $error("busy status not high");
  status_done_a: assert property (!sdo_oe_n_ff && $past(!sdo_oe_n_ff) && sleeping_ff
    && $past(sleeping_ff) |-> !sdo_ff) else $error("done status not low");
  reset_state_a: assert property ($fell(rst) |-> (converting_ff && !sleeping_ff) [*8])
    else $error("no conversion after reset");
  por_wait_a: assert property (sleeping_ff |-> up_cnt_ff >= POR_CYCLES + CONV_CYCLES)
    else $error("sleep before pulse and conversion");
  calib_inside_a: assert property (calibrating_ff |-> converting_ff)
    else $error("calibration outside conversion");
  mode_ext_a: assert property ($fell(cs_n) && !sck_in ##1 (!cs_n && !sck_in) [*5]
    |-> !int_sck_mode_ff) else $error("clock mode not external");
  // main scenarios reached
  cover property ($fell(cs_n) && sleeping_ff);
  cover property ($rose(int_sck_mode_ff));
  cover property (calibrating_ff);
endmodule
bind adc_cycle_ctrl adc_cycle_ctrl_sva #(
  .POR_CYCLES(POR_CYCLES),
  .CONV_CYCLES(CONV_CYCLES)
) chk_u (.*);
`default_nettype wire

/* sim/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************
// host on the serial port
// ****************
module host_model (
  // clock
  input  wire logic clk,
  // serial pins
  input  wire logic sdo,
  input  wire logic sdo_oe_n,
  output var  logic cs_n,
  output var  logic sck
);
  // released line has no pull: show inverse so stale data never matches
  wire sdo_line = sdo_oe_n ? ~sdo : sdo;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
  end
  // select with sck held at the wanted mode level
  task automatic select(input logic lvl);
    @(posedge clk);
    sck <= lvl;
    cs_n <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // deselect; early release means return to sleep or abort
  task automatic deselect;
    @(posedge clk);
    cs_n <= 1'b1;
    sck <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // link clock of 800 ns, phase unrelated to clk; idles low
  task automatic shift(input int n, output logic [23:0] w);
    w = 24'h000000;
    #130;
    for (int i = 0; i < n; i++) begin
      sck = 1'b1;
      w = {w[22:0], sdo_line};
      #400;
      sck = 1'b0;
      #400;
    end
  endtask
endmodule
`default_nettype wire

/* sim/adc_cycle_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_cycle_ctrl_tb;
  // ****************
  // signals
  // ****************
  localparam int POR_N  = 20;  // shortened power-on pulse
  localparam int CONV_N = 50;  // shortened conversion
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        supply_low = 1'b0;
  logic        sample_valid = 1'b0;
  logic [20:0] sample_data = 21'h000000;
  logic        sample_over = 1'b0;
  logic        sample_under = 1'b0;
  logic        sample_polarity = 1'b0;
  logic        sample_ready, cs_n, host_sck, sck_out_ff, sck_oe_n_ff, sdo_ff, sdo_oe_n_ff;
  logic        converting_ff, sleeping_ff, calibrating_ff, int_sck_mode_ff;
  wire         sck_in = sck_oe_n_ff ? host_sck : sck_out_ff;  // shared clock pin
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #50 clk = ~clk;
  adc_cycle_ctrl #(.POR_CYCLES(POR_N), .CONV_CYCLES(CONV_N)) dut_u (.*);
  host_model host_u (.clk(clk), .sdo(sdo_ff), .sdo_oe_n(sdo_oe_n_ff), .cs_n(cs_n), .sck(host_sck));
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected word; overrange wins when both flags are set
  function automatic logic [23:0] ef(input logic [20:0] d, input logic ov, un, pol);
    if (ov) return {3'b001, 21'h100000};
    if (un) return {3'b000, 21'h0FFFFF};
    return {2'b00, pol, d};
  endfunction
  // offer one sample, held until the fifo takes it
  task automatic push(input logic [20:0] d, input logic ov, un, pol);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_data <= d;
    sample_over <= ov;
    sample_under <= un;
    sample_polarity <= pol;
    do @(posedge clk); while (sample_ready !== 1'b1);
    sample_valid <= 1'b0;
  endtask
  task automatic wait_sleep(output int n);
    n = 0;
    while (sleeping_ff !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk(24'(sleeping_ff), 24'h000001);
  endtask
  // full read; afterwards busy status shows on the pin
  task automatic read_cmp(input logic [23:0] exp);
    logic [23:0] w;
    host_u.select(1'b0);
    host_u.shift(24, w);
    chk(w, exp);
    chk(24'({converting_ff, host_u.sdo_line}), 24'h000003);
    host_u.deselect();
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_power_up;
    int n, t0;
    t0 = cyc;
    @(posedge clk);
    chk(24'({converting_ff, sdo_oe_n_ff}), 24'h000003);
    push(21'h0A5A5A, 1'b0, 1'b0, 1'b1);
    wait_sleep(n);
    chk(24'(cyc - t0 >= POR_N + CONV_N), 24'h000001);
    read_cmp(ef(21'h0A5A5A, 1'b0, 1'b0, 1'b1));
  endtask
  task automatic t_early_deselect;
    int n;
    push(21'h15A5A5, 1'b0, 1'b0, 1'b0);
    wait_sleep(n);
    host_u.select(1'b0);
    chk(24'(host_u.sdo_line), 24'h000000);
    host_u.deselect();
    wait_sleep(n);
    read_cmp(ef(21'h15A5A5, 1'b0, 1'b0, 1'b0));
  endtask
  task automatic t_abort;
    int n;
    logic [23:0] w, e;
    e = ef(21'h1C3C3C, 1'b0, 1'b0, 1'b1);
    push(21'h1C3C3C, 1'b0, 1'b0, 1'b1);
    wait_sleep(n);
    host_u.select(1'b0);
    host_u.shift(5, w);
    chk(w, {19'h00000, e[23:19]});
    host_u.deselect();
    chk(24'({converting_ff, sleeping_ff}), 24'h000002);
  endtask
  // host stalls while the fifo fills, then drains it word by word
  task automatic t_fifo_range;
    int n;
    push(21'h0C0C0C, 1'b0, 1'b0, 1'b1);
    wait_sleep(n);
    // eight in storage plus one in the output register
    for (int i = 0; i < 9; i++)
      push(21'h0F0F00 + 21'(i), i == 2, i == 2 || i == 5, i[0]);
    @(posedge clk);
    chk(24'(sample_ready), 24'h000000);
    read_cmp(ef(21'h0C0C0C, 1'b0, 1'b0, 1'b1));
    for (int i = 0; i < 9; i++) begin
      wait_sleep(n);
      read_cmp(ef(21'h0F0F00 + 21'(i), i == 2, i == 2 || i == 5, i[0]));
    end
    repeat (CONV_N + 30) @(posedge clk);
    chk(24'(converting_ff), 24'h000001);
  endtask
  // device clocks itself out, then a select during conversion
  task automatic t_mode;
    int n;
    push(21'h012345, 1'b0, 1'b0, 1'b0);
    wait_sleep(n);
    host_u.select(1'b1);
    chk(24'(int_sck_mode_ff), 24'h000001);
    repeat (260) @(posedge clk);
    chk(24'({converting_ff, host_u.sdo_line}), 24'h000003);
    host_u.deselect();
    host_u.select(1'b0);
    chk(24'({int_sck_mode_ff, host_u.sdo_line}), 24'h000001);
    host_u.deselect();
  endtask
  task automatic t_supply;
    int n;
    @(posedge clk);
    supply_low <= 1'b1;
    repeat (8) @(posedge clk);
    chk(24'({converting_ff, sleeping_ff, sdo_oe_n_ff}), 24'h000005);
    supply_low <= 1'b0;
    repeat (POR_N + 10) @(posedge clk);
    push(21'h1ABCDE, 1'b0, 1'b0, 1'b1);
    wait_sleep(n);
    read_cmp(ef(21'h1ABCDE, 1'b0, 1'b0, 1'b1));
  endtask
  // ****************
  // run control
  // ****************
  task automatic conclude;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, well beyond the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_power_up();
    t_early_deselect();
    t_abort();
    t_fifo_range();
    t_mode();
    t_supply();
    conclude();
  end
endmodule
`default_nettype wire
